// ---- cic_pkg.sv ----
// Shared constants, field helpers and tables for the CIC front end and its partner
package cic_pkg;
	localparam int SAMPLE_W = 15;
	localparam int GAIN_W = 3;
	localparam int SG_W = 4;
	localparam int CNT_W = 6;
	localparam int ORDER = 5;
	localparam int ACC1_W = 40;
	localparam int ACC2_W = 36;
	localparam int ACC3_W = 32;
	localparam int OUT_W = 32;
	localparam int CW_W = 32;
	localparam int RATIO_W = 7;
	localparam int ADDR_W = 8;
	// Control word 0 field positions
	localparam int CW_BYPASS = 6;
	localparam int CW_PRE_LSB = 7;
	localparam int CW_SG_LSB = 13;
	localparam int CW_XSYNC = 19;
	localparam logic [CW_W-1:0] CW_RESET = 32'h0000_0000;
	localparam logic [SG_W-1:0] SG_MAX = 4'hF;
	// Two-entry output buffer
	localparam logic [1:0] BUF_EMPTY = 2'h0;
	localparam logic [1:0] BUF_FULL = 2'h2;
	// Partner register map (byte offsets, one word each)
	localparam logic [ADDR_W-1:0] REG_CFG = 8'h00;
	localparam logic [ADDR_W-1:0] REG_SAMPLE = 8'h04;
	localparam logic [ADDR_W-1:0] REG_SYNC = 8'h08;
	localparam logic [ADDR_W-1:0] REG_OUT = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
	localparam int SMP_GAIN_LSB = 16;
	localparam int ST_PEND = 0;
	localparam int ST_AVAIL = 1;
	localparam int ST_OVER = 2;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	function automatic logic [CNT_W-1:0] cw_preload(input logic [CW_W-1:0] cw);
		return cw[CW_PRE_LSB +: CNT_W];
	endfunction : cw_preload

	function automatic logic [SG_W-1:0] cw_shift_gain(input logic [CW_W-1:0] cw);
		return cw[CW_SG_LSB +: SG_W];
	endfunction : cw_shift_gain

	// Shift = shift gain + gain offset, clamped to the largest shift
	function automatic logic [SG_W-1:0] sat_shift(input logic [SG_W-1:0] sg,
		input logic [GAIN_W-1:0] g);
		logic [SG_W:0] s;
		s = {1'b0, sg} + {2'b00, g};
		return s[SG_W] ? SG_MAX : s[SG_W-1:0];
	endfunction : sat_shift

	// Largest safe decimation ratio for each gain offset code
	function automatic logic [RATIO_W-1:0] max_ratio(input logic [GAIN_W-1:0] g);
		logic [RATIO_W-1:0] r;
		case (g)
			3'h0: r = 7'h20;
			3'h1: r = 7'h1B;
			3'h2: r = 7'h18;
			3'h3: r = 7'h15;
			3'h4: r = 7'h12;
			3'h5: r = 7'h10;
			3'h6: r = 7'h0C;
			default: r = 7'h0A;
		endcase
		return r;
	endfunction : max_ratio
endpackage : cic_pkg

// ---- cic_link_if.sv ----
// Link between the CIC front end and the mixer/halfband partner
`timescale 1ns/1ps
interface cic_link_if;
	logic [cic_pkg::SAMPLE_W-1:0] mix_sample;
	logic [cic_pkg::GAIN_W-1:0] gain_offset_pins;
	logic input_sample_enable_n;
	logic sample_ready;
	logic external_sync_input;
	logic [cic_pkg::CW_W-1:0] cfg_word;
	logic cfg_load;
	logic [cic_pkg::OUT_W-1:0] dec_data;
	logic dec_valid;
	logic dec_ready;

	modport dev (
		input mix_sample,
		input gain_offset_pins,
		input input_sample_enable_n,
		input external_sync_input,
		input cfg_word,
		input cfg_load,
		input dec_ready,
		output sample_ready,
		output dec_data,
		output dec_valid
	);

	modport src (
		output mix_sample,
		output gain_offset_pins,
		output input_sample_enable_n,
		output external_sync_input,
		output cfg_word,
		output cfg_load,
		output dec_ready,
		input sample_ready,
		input dec_data,
		input dec_valid
	);
endinterface : cic_link_if

// ---- cic_buf2.sv ----
// Two-entry valid/ready buffer on the decimated output path
`timescale 1ns/1ps
module cic_buf2 #(
	parameter int W = cic_pkg::OUT_W
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic wp;
		logic rp;
		logic [1:0] cnt;
	} cic_buf_s;

	cic_buf_s q;
	cic_buf_s d;
	logic push;
	logic pop;

	assign in_ready = q.cnt != cic_pkg::BUF_FULL;
	assign out_valid = q.cnt != cic_pkg::BUF_EMPTY;
	assign out_data = q.mem[q.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wp] = in_data;
			d.wp = ~q.wp;
		end
		if (pop) begin
			d.rp = ~q.rp;
		end
		if (push && !pop) begin
			d.cnt = q.cnt + 2'h1;
		end else if (pop && !push) begin
			d.cnt = q.cnt - 2'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
endmodule : cic_buf2

// ---- cic_front_end.sv ----
// Barrel shifter and fifth-order CIC decimator, device end of the link
//
// Notes on behaviour
// - Barrel shift input by shift gain plus offset
// - Gain offset pipelined alongside its sample
// - Shift sum saturates at fifteen
// - Five integrators then five comb sections
// - Control word 0 holds preload, gain, bypass
// - Bypass sends mixer samples straight out
// - Source gaps enable between samples in bypass
// - 15-bit input; accumulators 40,36,32,32,32 bits
// - Software keeps ratio at most 32
// - Six-bit counter loaded with ratio minus one
// - Each offset code adds one 6dB step
// - Outside bypass, source flags ratio above the limit for its gain offset code
// - Software picks shift gain from formula
// - External sync reloads counter when enabled
// - Mixer delivers rounded 15-bit samples
// - Advance only on enabled input samples
`timescale 1ns/1ps
module cic_front_end (
	input wire logic sys_clk,
	input wire logic rst_n,
	cic_link_if.dev link,
	output logic [cic_pkg::CNT_W-1:0] decim_count,
	output logic bypass_on
);
	typedef struct packed {
		logic [cic_pkg::CW_W-1:0] cw;
		logic s0_valid;
		logic [cic_pkg::SAMPLE_W-1:0] s0_sample;
		logic [cic_pkg::GAIN_W-1:0] s0_gain;
		logic [cic_pkg::ACC1_W-1:0] acc1;
		logic [cic_pkg::ACC2_W-1:0] acc2;
		logic [cic_pkg::ACC3_W-1:0] acc3;
		logic [cic_pkg::ACC3_W-1:0] acc4;
		logic [cic_pkg::ACC3_W-1:0] acc5;
		logic [cic_pkg::ORDER-1:0][cic_pkg::OUT_W-1:0] comb_dly;
		logic [cic_pkg::CNT_W-1:0] cnt;
	} cic_fe_s;

	cic_fe_s q;
	cic_fe_s d;
	logic bypass;
	logic fire;
	logic s0_go;
	logic buf_in_ready;
	logic [cic_pkg::SG_W-1:0] shift;
	logic [cic_pkg::ACC1_W-1:0] s0_ext;
	logic [cic_pkg::ACC1_W-1:0] shifted;
	logic [cic_pkg::OUT_W-1:0] byp_word;
	logic [cic_pkg::OUT_W-1:0] comb_out;
	logic [cic_pkg::OUT_W-1:0] push_word;

	assign bypass = q.cw[cic_pkg::CW_BYPASS];
	// An output is due when stage 0 holds a sample and either bypass is on or the counter has run out
	assign fire = q.s0_valid && (bypass || q.cnt == '0);
	// Stage 0 holds its sample while the output buffer refuses a due word
	assign s0_go = q.s0_valid && (!fire || buf_in_ready);
	assign link.sample_ready = !q.s0_valid || s0_go;

	// Offset code adds 6dB per step on top of the programmed shift gain
	assign shift = cic_pkg::sat_shift(cic_pkg::cw_shift_gain(q.cw), q.s0_gain);
	assign s0_ext = {{(cic_pkg::ACC1_W - cic_pkg::SAMPLE_W){q.s0_sample[cic_pkg::SAMPLE_W-1]}},
		q.s0_sample};
	assign shifted = s0_ext << shift;
	assign byp_word = {{(cic_pkg::OUT_W - cic_pkg::SAMPLE_W){q.s0_sample[cic_pkg::SAMPLE_W-1]}},
		q.s0_sample};
	assign push_word = bypass ? byp_word : comb_out;

	// Comb chain on the last integrator, evaluated every cycle, stored on output
	always_comb begin
		logic [cic_pkg::OUT_W-1:0] x;
		x = q.acc5;
		for (int k = 0; k < cic_pkg::ORDER; k++) begin
			x = x - q.comb_dly[k];
		end
		comb_out = x;
	end

	always_comb begin
		logic [cic_pkg::OUT_W-1:0] x;
		d = q;
		x = q.acc5;
		// Sample and its gain offset enter stage 0 together
		if (link.sample_ready) begin
			d.s0_valid = !link.input_sample_enable_n;
			if (!link.input_sample_enable_n) begin
				d.s0_sample = link.mix_sample;
				d.s0_gain = link.gain_offset_pins;
			end
		end
		if (s0_go && !bypass) begin
			// Pruned integrator cascade, each stage fed by the previous state
			d.acc1 = q.acc1 + shifted;
			d.acc2 = q.acc2 + q.acc1[cic_pkg::ACC1_W-1 -: cic_pkg::ACC2_W];
			d.acc3 = q.acc3 + q.acc2[cic_pkg::ACC2_W-1 -: cic_pkg::ACC3_W];
			d.acc4 = q.acc4 + q.acc3;
			d.acc5 = q.acc5 + q.acc4;
			if (q.cnt == '0) begin
				for (int k = 0; k < cic_pkg::ORDER; k++) begin
					d.comb_dly[k] = x;
					x = x - q.comb_dly[k];
				end
				d.cnt = cic_pkg::cw_preload(q.cw);
			end else begin
				d.cnt = q.cnt - 6'h01;
			end
		end
		if (link.cfg_load) begin
			d.cw = link.cfg_word;
			d.cnt = cic_pkg::cw_preload(link.cfg_word);
		end else if (q.cw[cic_pkg::CW_XSYNC] && link.external_sync_input) begin
			d.cnt = cic_pkg::cw_preload(q.cw);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			q <= '0;
			q.cw <= cic_pkg::CW_RESET;
		end else begin
			q <= d;
		end
	end

	cic_buf2 #(
		.W(cic_pkg::OUT_W)
	) u_out_buf (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.in_valid(fire),
		.in_data(push_word),
		.in_ready(buf_in_ready),
		.out_valid(link.dec_valid),
		.out_data(link.dec_data),
		.out_ready(link.dec_ready)
	);

	assign decim_count = q.cnt;
	assign bypass_on = bypass;
endmodule : cic_front_end

// ---- cic_mixer_port.sv ----
// Partner end: AHB-Lite register port that feeds samples and drains decimated words
`timescale 1ns/1ps
module cic_mixer_port (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	cic_link_if.src link
);
	typedef struct packed {
		logic dp_wr;
		logic [cic_pkg::ADDR_W-1:0] dp_addr;
		logic [cic_pkg::CW_W-1:0] cw;
		logic [cic_pkg::SAMPLE_W-1:0] smp;
		logic [cic_pkg::GAIN_W-1:0] gain;
		logic pend;
		logic gap;
		logic sync;
		logic cfgld;
		logic [31:0] rdata;
	} cic_mp_s;

	cic_mp_s q;
	cic_mp_s d;
	logic aphase;
	logic stall;
	logic send;
	logic over;
	logic [cic_pkg::ADDR_W-1:0] a_off;
	logic [cic_pkg::RATIO_W-1:0] ratio;

	assign a_off = haddr[cic_pkg::ADDR_W-1:0];
	assign aphase = hsel && htrans == cic_pkg::HTRANS_NONSEQ && hready;
	// A second sample write waits until the previous one has gone out
	assign stall = q.dp_wr && q.dp_addr == cic_pkg::REG_SAMPLE && q.pend;
	assign hreadyout = !stall;
	assign hrdata = q.rdata;
	assign hresp = 1'b0;
	// In bypass the enable is gapped for one cycle after every sample
	assign send = q.pend && !q.gap && link.sample_ready;
	assign ratio = {1'b0, cic_pkg::cw_preload(q.cw)} + 7'h01;
	assign over = !q.cw[cic_pkg::CW_BYPASS] && ratio > cic_pkg::max_ratio(q.gain);

	always_comb begin
		d = q;
		d.sync = 1'b0;
		d.cfgld = 1'b0;
		d.gap = send && q.cw[cic_pkg::CW_BYPASS];
		if (send) begin
			d.pend = 1'b0;
		end
		if (q.dp_wr && !stall) begin
			d.dp_wr = 1'b0;
			if (q.dp_addr == cic_pkg::REG_CFG) begin
				d.cw = hwdata;
				d.cfgld = 1'b1;
			end else if (q.dp_addr == cic_pkg::REG_SAMPLE) begin
				d.smp = hwdata[cic_pkg::SAMPLE_W-1:0];
				d.gain = hwdata[cic_pkg::SMP_GAIN_LSB +: cic_pkg::GAIN_W];
				d.pend = 1'b1;
			end else if (q.dp_addr == cic_pkg::REG_SYNC) begin
				d.sync = 1'b1;
			end
		end
		if (aphase) begin
			d.dp_wr = hwrite;
			d.dp_addr = a_off;
			d.rdata = '0;
			if (!hwrite) begin
				if (a_off == cic_pkg::REG_CFG) begin
					d.rdata = q.cw;
				end else if (a_off == cic_pkg::REG_SAMPLE) begin
					d.rdata[cic_pkg::SAMPLE_W-1:0] = q.smp;
					d.rdata[cic_pkg::SMP_GAIN_LSB +: cic_pkg::GAIN_W] = q.gain;
				end else if (a_off == cic_pkg::REG_OUT) begin
					d.rdata = link.dec_valid ? link.dec_data : '0;
				end else if (a_off == cic_pkg::REG_STATUS) begin
					d.rdata[cic_pkg::ST_PEND] = q.pend;
					d.rdata[cic_pkg::ST_AVAIL] = link.dec_valid;
					d.rdata[cic_pkg::ST_OVER] = over;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			q <= '0;
			q.cw <= cic_pkg::CW_RESET;
		end else begin
			q <= d;
		end
	end

	assign link.mix_sample = q.smp;
	assign link.gain_offset_pins = q.gain;
	assign link.input_sample_enable_n = !send;
	assign link.external_sync_input = q.sync;
	assign link.cfg_word = q.cw;
	assign link.cfg_load = q.cfgld;
	assign link.dec_ready = aphase && !hwrite && a_off == cic_pkg::REG_OUT;
endmodule : cic_mixer_port

// ---- cic_link_properties.sv ----
// Concurrent checks on the link between the CIC front end and its partner
`timescale 1ns/1ps
module cic_link_properties (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [cic_pkg::SAMPLE_W-1:0] mix_sample,
	input wire logic input_sample_enable_n,
	input wire logic sample_ready,
	input wire logic [cic_pkg::CW_W-1:0] cfg_word,
	input wire logic cfg_load,
	input wire logic [cic_pkg::OUT_W-1:0] dec_data,
	input wire logic dec_valid,
	input wire logic dec_ready
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	reset_state_a: assert property (disable iff (1'b0)
		!rst_n |=> !dec_valid && input_sample_enable_n && !cfg_load)
		else $error("state not cleared by reset");
	// Reset itself clears the word, so the edge just after release is left out
	cfg_pulse_a: assert property ($past(rst_n) && $changed(cfg_word) |-> cfg_load)
		else $error("control word changed without load");
	enable_ready_a: assert property (!input_sample_enable_n |-> sample_ready)
		else $error("sample offered while not ready");
	stall_full_a: assert property (!sample_ready |-> dec_valid)
		else $error("input stalled with room in buffer");
	hold_out_a: assert property (dec_valid && !dec_ready |=> dec_valid && $stable(dec_data))
		else $error("output word lost or changed");
	bypass_pass_a: assert property (
		!input_sample_enable_n && cfg_word[6] && !cfg_load && !$past(cfg_load) && !dec_valid
		|-> ##2 dec_valid && dec_data == {{17{$past(mix_sample[14], 2)}}, $past(mix_sample, 2)})
		else $error("bypass word wrong");
	unity_ratio_a: assert property (
		!input_sample_enable_n && cfg_word[12:7] == 6'h00 && !cfg_word[6] && !cfg_load
		&& !$past(cfg_load) && !dec_valid |-> ##2 dec_valid)
		else $error("ratio one gave no output");
	gap_after_a: assert property (!input_sample_enable_n && cfg_word[6] |=> input_sample_enable_n)
		else $error("bypass samples not gapped");
endmodule : cic_link_properties

// ---- cic_decimator_front_end_bench.sv ----
// Bench driving the CIC front end through its AHB partner port
`timescale 1ns/1ps
module cic_decimator_front_end_bench;
	typedef struct packed {
		logic [3:0] sg;
		logic [2:0] g;
		logic byp;
		logic [14:0] smp;
		logic [31:0] ex;
	} cic_row_s;
	logic sys_clk;
	logic rst_n;
	logic hsel;
	logic hwrite;
	logic hready;
	logic hresp;
	logic bypass_on;
	logic [1:0] htrans;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rd;
	logic [5:0] decim_count;
	int num_errors = 0;
	int n_tests = 0;
	cic_row_s rows [6];
	cic_link_if link();
	cic_front_end i_cic_front_end (.sys_clk(sys_clk), .rst_n(rst_n), .link(link.dev),
		.decim_count(decim_count), .bypass_on(bypass_on));
	cic_mixer_port i_cic_mixer_port (.sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .link(link.src));
	cic_link_properties i_cic_link_properties (.sys_clk(sys_clk), .rst_n(rst_n),
		.mix_sample(link.mix_sample), .input_sample_enable_n(link.input_sample_enable_n),
		.sample_ready(link.sample_ready), .cfg_word(link.cfg_word), .cfg_load(link.cfg_load),
		.dec_data(link.dec_data), .dec_valid(link.dec_valid), .dec_ready(link.dec_ready));

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
			num_errors++;
		end
	endtask : chk

	// One single AHB transfer; read data lands in rd
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= cic_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		@(posedge sys_clk iff hready === 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge sys_clk iff hready === 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic cfg(input logic [3:0] sg, input logic [5:0] pre, input logic byp,
		input logic xs);
		bus(1'b1, cic_pkg::REG_CFG, {12'h000, xs, 2'h0, sg, pre, byp, 6'h00});
	endtask : cfg

	task automatic smp(input logic [2:0] g, input logic [14:0] v);
		bus(1'b1, cic_pkg::REG_SAMPLE, {13'h0000, g, 1'b0, v});
	endtask : smp

	task automatic get_out();
		do bus(1'b0, cic_pkg::REG_STATUS, 32'h0); while (rd[cic_pkg::ST_AVAIL] !== 1'b1);
		bus(1'b0, cic_pkg::REG_OUT, 32'h0);
	endtask : get_out

	// Status read gives the pipeline time to settle before the count is looked at
	task automatic cnt(input logic [5:0] e);
		bus(1'b0, cic_pkg::REG_STATUS, 32'h0);
		@(negedge sys_clk);
		chk("decimation count", {26'h0, e}, {26'h0, decim_count});
		@(posedge sys_clk);
	endtask : cnt

	initial begin
		#200000;
		num_errors++;
		end_of_test();
	end

	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		// Ratio one passes samples through; unit input shifted by s reads back 2**(s-8)
		rows = '{'{4'h8, 3'h0, 1'b0, 15'h0001, 32'h1}, '{4'h9, 3'h1, 1'b0, 15'h0001, 32'h4},
			'{4'h8, 3'h3, 1'b0, 15'h0001, 32'h8}, '{4'hE, 3'h4, 1'b0, 15'h0001, 32'h80},
			'{4'hF, 3'h7, 1'b0, 15'h0001, 32'h80},
			'{4'h3, 3'h0, 1'b1, 15'h4001, 32'hFFFFC001}};
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		foreach (rows[i]) begin
			cfg(rows[i].sg, 6'h00, rows[i].byp, 1'b0);
			repeat (rows[i].byp ? 1 : 10) begin
				smp(rows[i].g, rows[i].smp);
				get_out();
			end
			chk("row output", rows[i].ex, rd);
			chk("bypass flag", {31'h0, rows[i].byp}, {31'h0, bypass_on});
			$display("Row %0d done", i);
		end
		cfg(4'hE, 6'h03, 1'b0, 1'b1);
		repeat (5) smp(3'h0, 15'h0001);
		cnt(6'h02);
		chk("one output", 32'h1, {31'h0, rd[cic_pkg::ST_AVAIL]});
		bus(1'b1, cic_pkg::REG_SYNC, 32'h0);
		cnt(6'h03);
		get_out();
		cfg(4'h8, 6'h03, 1'b0, 1'b0);
		smp(3'h0, 15'h0001);
		bus(1'b1, cic_pkg::REG_SYNC, 32'h0);
		cnt(6'h02);
		$display("Ratio and sync test done");
		cfg(4'h0, 6'h00, 1'b1, 1'b0);
		for (int k = 1; k < 5; k++) smp(3'h0, 15'(k));
		for (int k = 1; k < 5; k++) begin
			get_out();
			chk("buffered word", 32'(k), rd);
		end
		$display("Buffer test done");
		// Ratio 12 is above the limit for the top gain offset code
		cfg(4'h0, 6'h0B, 1'b0, 1'b0);
		smp(3'h7, 15'h0000);
		bus(1'b0, cic_pkg::REG_STATUS, 32'h0);
		chk("limit flag", 32'h1, {31'h0, rd[cic_pkg::ST_OVER]});
		$display("Limit test done");
		smp(3'h0, 15'h0005);
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		cnt(6'h00);
		chk("status", 32'h0, rd);
		bus(1'b1, 8'h20, 32'hFFFFFFFF);
		bus(1'b0, 8'h20, 32'h0);
		chk("unmapped", 32'h0, rd);
		bus(1'b0, cic_pkg::REG_CFG, 32'h0);
		chk("control word", 32'h0, rd);
		chk("response", 32'h0, {31'h0, hresp});
		$display("Reset test done");
		end_of_test();
	end
endmodule : cic_decimator_front_end_bench
